// ### rtl/ccs_map.svh
// Purpose: Register map, field positions, reset values and fixed figures of the scheduler.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// Register byte offsets on the APB port.
`define CCS_ADDR_W 8
`define CCS_OFF_CTRL 8'h00
`define CCS_OFF_PERIOD 8'h04
`define CCS_OFF_BURST 8'h08
`define CCS_OFF_STATUS 8'h0C
`define CCS_OFF_TIMEOUT 8'h10

// Control register fields and reset values.
`define CCS_CTRL_AUTO 0
`define CCS_CTRL_LIVE 1
`define CCS_CTRL_FORCE 2
`define CCS_CTRL_RST 3'h3

// Status register fields.
`define CCS_ST_CHUP 0
`define CCS_ST_REQ 1
`define CCS_ST_LRST 2
`define CCS_ST_TXB_LO 8
`define CCS_ST_RXB_LO 12

// Transceiver lane widths in bytes.
`define CCS_TX_BYTES 4'h8
`define CCS_RX_BYTES 4'h4

// Cycles that the link reset stands after a missed compensation timeout.
`define CCS_LRST_LEN 8'h80

`endif

// ### rtl/ccs_pkg.sv
// Purpose: Types shared by the scheduler design files.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Numbers live in ccs_map.svh.
package ccs_pkg;

    typedef enum logic [0:0] {
        CCS_HP_WATCH,
        CCS_HP_RESET
    } ccs_hp_state_t;

endpackage

// ### rtl/ccs_cycle_cnt.sv
// Purpose: Free counter that wraps at a programmable limit.
// Assumes: Clear has priority over counting; ce freezes the count.
// Notes: wrap is high in the cycle the count sits at its limit.
`timescale 1ns/1ps
`default_nettype none
module ccs_cycle_cnt #(
    parameter int W = 16
) (
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic clear,
    input wire logic [W-1:0] limit,
    // State
    output logic [W-1:0] count,
    output logic wrap
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    assign wrap = (count_r == limit);
    assign count = count_r;

    always_comb begin
        count_nxt = count_r;
        if (clear || wrap) begin
            count_nxt = '0;
        end else begin
            count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (ce) begin
            count_r <= count_nxt;
        end
    end

endmodule
`default_nettype wire

// ### rtl/ccs_top.sv
// Purpose: Clock compensation scheduler with transmit ready gating and a hot-plug watchdog.
// Assumes: All link-side inputs come from logic on pclk, the single user clock.
// Notes: Registers sit on a zero-wait APB slave; every output is registered.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_map.svh"

// Function
// - Raise the compensation request three cycles in every 10,000 cycles.
// - Hold transmit ready low toward the user while the request is high.
// - Generate request pulses autonomously and drive them on the request output.
// - Send compensation whenever the request is high, any time, any length.
// - Transmit lane eight bytes, receive lane four, user path eight-byte aligned.
// - Reset the link when no compensation is received within the timeout.
module ccs_top
    import ccs_pkg::*;
#(
    parameter logic [15:0] PERIOD_CYC = 16'h2710,
    parameter logic [15:0] BURST_CYC = 16'h0003,
    parameter logic [23:0] TIMEOUT_CYC = 24'h00C350,
    parameter int CNT_W = 16,
    parameter int WD_W = 24
) (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CCS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link core side
    input wire logic channel_up,
    input wire logic core_tx_ready,
    input wire logic rx_comp_seen,
    output logic comp_request,
    output logic user_tx_ready,
    output logic link_reset
);

    // Register state.
    logic [2:0] ctrl_r;
    logic [2:0] ctrl_nxt;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] period_nxt;
    logic [CNT_W-1:0] burst_r;
    logic [CNT_W-1:0] burst_nxt;
    logic [WD_W-1:0] timeout_r;
    logic [WD_W-1:0] timeout_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    // Scheduler and gating state.
    logic req_r;
    logic req_nxt;
    logic txr_r;
    logic txr_nxt;
    logic auto_run;
    logic [CNT_W-1:0] sched_cnt;

    // Hot-plug state.
    ccs_hp_state_t hp_r;
    ccs_hp_state_t hp_nxt;
    logic [7:0] lrst_cnt_r;
    logic [7:0] lrst_cnt_nxt;
    logic lrst_r;
    logic lrst_nxt;
    logic wd_clear;
    logic wd_wrap;

    logic setup;
    logic wr_en;
    logic hit;
    logic [31:0] rd_mux;
    logic [31:0] status;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_r && pwrite;

    // Live insertion forces the periodic pattern on, since the watchdog lives on it.
    assign auto_run = (ctrl_r[`CCS_CTRL_AUTO] || ctrl_r[`CCS_CTRL_LIVE]) && channel_up;

    ccs_cycle_cnt #(
        .W(CNT_W)
    ) u_period (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .clear(!auto_run),
        .limit(period_r - {{(CNT_W-1){1'b0}}, 1'b1}),
        .count(sched_cnt),
        .wrap()
    );

    ccs_cycle_cnt #(
        .W(WD_W)
    ) u_watchdog (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .clear(wd_clear),
        .limit(timeout_r),
        .count(),
        .wrap(wd_wrap)
    );

    always_comb begin
        status = '0;
        status[`CCS_ST_CHUP] = channel_up;
        status[`CCS_ST_REQ] = req_r;
        status[`CCS_ST_LRST] = lrst_r;
        status[`CCS_ST_TXB_LO +: 4] = `CCS_TX_BYTES;
        status[`CCS_ST_RXB_LO +: 4] = `CCS_RX_BYTES;
        hit = 1'b1;
        rd_mux = '0;
        case (paddr)
            `CCS_OFF_CTRL: rd_mux[2:0] = ctrl_r;
            `CCS_OFF_PERIOD: rd_mux[CNT_W-1:0] = period_r;
            `CCS_OFF_BURST: rd_mux[CNT_W-1:0] = burst_r;
            `CCS_OFF_STATUS: rd_mux = status;
            `CCS_OFF_TIMEOUT: rd_mux[WD_W-1:0] = timeout_r;
            default: hit = 1'b0;
        endcase
    end

    // The answer is prepared in the setup cycle so pready can come from a flop
    // without adding a wait state.
    always_comb begin
        ctrl_nxt = ctrl_r;
        period_nxt = period_r;
        burst_nxt = burst_r;
        timeout_nxt = timeout_r;
        pready_nxt = setup;
        prdata_nxt = setup ? rd_mux : prdata_r;
        pslverr_nxt = setup ? !hit : pslverr_r;
        if (wr_en) begin
            case (paddr)
                `CCS_OFF_CTRL: ctrl_nxt = pwdata[2:0];
                `CCS_OFF_PERIOD: period_nxt = pwdata[CNT_W-1:0];
                `CCS_OFF_BURST: burst_nxt = pwdata[CNT_W-1:0];
                `CCS_OFF_TIMEOUT: timeout_nxt = pwdata[WD_W-1:0];
                default: ctrl_nxt = ctrl_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CCS_CTRL_RST;
            period_r <= PERIOD_CYC;
            burst_r <= BURST_CYC;
            timeout_r <= TIMEOUT_CYC;
            pready_r <= 1'b0;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            period_r <= period_nxt;
            burst_r <= burst_nxt;
            timeout_r <= timeout_nxt;
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Request and ready are computed from the same next value, so the user never
    // sees ready high in a cycle where the core is sending compensation.
    always_comb begin
        req_nxt = (auto_run && (sched_cnt < burst_r))
            || ctrl_r[`CCS_CTRL_FORCE];
        txr_nxt = core_tx_ready && !req_nxt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r <= 1'b0;
            txr_r <= 1'b0;
        end else if (ce) begin
            req_r <= req_nxt;
            txr_r <= txr_nxt;
        end
    end

    // The watchdog restarts on each received compensation; a missed window
    // resets the link for a fixed stretch and then watches again.
    assign wd_clear = rx_comp_seen || !ctrl_r[`CCS_CTRL_LIVE] || (hp_r == CCS_HP_RESET);

    always_comb begin
        hp_nxt = hp_r;
        lrst_cnt_nxt = lrst_cnt_r;
        lrst_nxt = 1'b0;
        case (hp_r)
            CCS_HP_WATCH: begin
                if (ctrl_r[`CCS_CTRL_LIVE] && !rx_comp_seen && wd_wrap) begin
                    hp_nxt = CCS_HP_RESET;
                    lrst_cnt_nxt = '0;
                    lrst_nxt = 1'b1;
                end
            end
            CCS_HP_RESET: begin
                lrst_nxt = 1'b1;
                lrst_cnt_nxt = lrst_cnt_r + 8'h01;
                if (lrst_cnt_r == `CCS_LRST_LEN - 8'h01) begin
                    hp_nxt = CCS_HP_WATCH;
                    lrst_nxt = 1'b0;
                end
            end
            default: hp_nxt = CCS_HP_WATCH;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hp_r <= CCS_HP_WATCH;
            lrst_cnt_r <= '0;
            lrst_r <= 1'b0;
        end else if (ce) begin
            hp_r <= hp_nxt;
            lrst_cnt_r <= lrst_cnt_nxt;
            lrst_r <= lrst_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign comp_request = req_r;
    assign user_tx_ready = txr_r;
    assign link_reset = lrst_r;

endmodule
`default_nettype wire

// ### test/ccs_top_properties.sv
// Purpose: Port-level timing checks of the compensation scheduler.
// Assumes: ce is held high and the FORCE bit stays clear.
// Notes: Bound into ccs_top at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module ccs_top_chk #(
    parameter logic [15:0] PERIOD_CYC = 16'h2710,
    parameter logic [23:0] TIMEOUT_CYC = 24'h00C350
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Link side
    input wire logic channel_up,
    input wire logic core_tx_ready,
    input wire logic rx_comp_seen,
    input wire logic comp_request,
    input wire logic user_tx_ready,
    input wire logic link_reset
);
    logic [15:0] gap_r;
    logic fresh_r;
    logic [7:0] lr_r;
    logic [23:0] q_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A rise right after channel-up has no earlier burst to be measured from.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 16'h0;
            fresh_r <= 1'b1;
            lr_r <= 8'h0;
            q_r <= 24'h0;
        end else begin
            gap_r <= $rose(comp_request) ? 16'h0 : gap_r + 16'h1;
            fresh_r <= !channel_up || (fresh_r && !$rose(comp_request));
            lr_r <= link_reset ? lr_r + 8'h1 : 8'h0;
            q_r <= rx_comp_seen ? 24'h0 : q_r + 24'h1;
        end
    end
    AST_TX_GATE: assert property (comp_request |-> !user_tx_ready)
        else $error("user ready high during request");
    AST_TX_FOLLOW: assert property ($past(presetn) && !comp_request
        |-> user_tx_ready == $past(core_tx_ready))
        else $error("user ready does not follow core ready");
    AST_BURST: assert property ($rose(comp_request)
        |-> comp_request [*3] ##1 !comp_request)
        else $error("request burst is not three cycles");
    AST_PERIOD: assert property ($rose(comp_request) && !fresh_r
        |-> gap_r == PERIOD_CYC - 16'h1)
        else $error("request period wrong");
    AST_IDLE_DOWN: assert property (!channel_up |=> !comp_request)
        else $error("request while channel down");
    AST_START: assert property ($rose(channel_up) |=> comp_request)
        else $error("request did not start after channel up");
    AST_PREADY: assert property (psel && !penable |=> pready)
        else $error("pready missing in access phase");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_LRST_LEN: assert property ($fell(link_reset) |-> lr_r == 8'h80)
        else $error("link reset length wrong");
    AST_LRST_MAX: assert property (lr_r <= 8'h80)
        else $error("link reset too long");
    AST_TIMEOUT: assert property ($rose(link_reset) |-> q_r >= TIMEOUT_CYC)
        else $error("link reset before timeout");
endmodule
bind ccs_top ccs_top_chk #(.PERIOD_CYC(PERIOD_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
    .pclk, .presetn, .psel, .penable, .pready, .channel_up, .core_tx_ready,
    .rx_comp_seen, .comp_request, .user_tx_ready, .link_reset);
`default_nettype wire

// ### test/ccs_far_model.sv
// Purpose: Link core and remote partner as seen by the scheduler.
// Assumes: Runs on the single user clock.
// Notes: Echo can be cut to imitate a broken link.
`timescale 1ns/1ps
`default_nettype none
module ccs_far_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control and scheduler request
    input wire logic echo_en,
    input wire logic comp_request,
    // Core toward the scheduler
    output logic core_tx_ready,
    output logic rx_comp_seen
);
    logic [1:0] ph_r;
    // The core is busy one cycle in four so the gating is seen against both levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= 2'h0;
            core_tx_ready <= 1'b0;
            rx_comp_seen <= 1'b0;
        end else begin
            ph_r <= ph_r + 2'h1;
            core_tx_ready <= ph_r != 2'h3;
            rx_comp_seen <= echo_en && comp_request;
        end
    end
endmodule
`default_nettype wire

// ### test/ccs_top_test.sv
// Purpose: Self-checking bench of the compensation scheduler.
// Assumes: Shortened period of 40 and timeout of 100 cycles.
// Notes: ce is tied high.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_map.svh"
module ccs_top_test;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, channel_up, echo_en, pready, pslverr, er;
    logic core_tx_ready, rx_comp_seen, comp_request, user_tx_ready, link_reset;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int miscompares = 0;
    int total_checks = 0;
    always #20 pclk = ~pclk;
    // A short period keeps bursts well apart yet shows every burst within a few tasks.
    ccs_top #(.PERIOD_CYC(16'h0028), .TIMEOUT_CYC(24'h000064))
        dut (.pclk, .presetn, .ce(1'b1),
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_up,
        .core_tx_ready, .rx_comp_seen, .comp_request, .user_tx_ready, .link_reset);
    ccs_far_model far (.pclk, .presetn, .echo_en, .comp_request, .core_tx_ready,
        .rx_comp_seen);
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for an answer that never comes.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_regs;
        apb(1'b0, `CCS_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h3, rd);
        apb(1'b0, `CCS_OFF_PERIOD, 32'h0);
        chk("period", 32'h28, rd);
        apb(1'b0, `CCS_OFF_BURST, 32'h0);
        chk("burst_rst", 32'h3, rd);
        apb(1'b1, `CCS_OFF_BURST, 32'h5);
        apb(1'b0, `CCS_OFF_BURST, 32'h0);
        chk("burst", 32'h5, rd);
        apb(1'b1, `CCS_OFF_BURST, 32'h3);
        apb(1'b0, `CCS_OFF_TIMEOUT, 32'h0);
        chk("timeout", 32'h64, rd);
        apb(1'b1, `CCS_OFF_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, `CCS_OFF_STATUS, 32'h0);
        chk("status", 32'h4800, rd);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], er});
    endtask
    task t_sched;
        int hi;
        int first;
        hi = 0;
        first = -1;
        @(posedge pclk);
        channel_up <= 1'b1;
        for (int i = 1; i <= 81; i++) begin
            @(negedge pclk);
            if (comp_request === 1'b1) begin
                hi++;
                if (first < 0) first = i;
                chk("tx_gate", 32'h0, {31'h0, user_tx_ready});
            end
        end
        chk("first_req", 32'h2, first);
        chk("req_cycles", 32'h6, hi);
    endtask
    task t_down;
        int hi;
        hi = 0;
        repeat (6) @(negedge pclk);
        @(posedge pclk);
        channel_up <= 1'b0;
        repeat (60) begin
            @(negedge pclk);
            if (comp_request !== 1'b0) hi++;
        end
        chk("down_req", 32'h0, hi);
        @(posedge pclk);
        channel_up <= 1'b1;
        repeat (2) @(negedge pclk);
        chk("restart", 32'h1, {31'h0, comp_request});
    endtask
    task t_off;
        int hi;
        hi = 0;
        apb(1'b1, `CCS_OFF_CTRL, 32'h0);
        repeat (45) begin
            @(negedge pclk);
            if (comp_request !== 1'b0) hi++;
        end
        chk("off_req", 32'h0, hi);
        @(posedge pclk);
        channel_up <= 1'b0;
        apb(1'b1, `CCS_OFF_CTRL, 32'h3);
        @(posedge pclk);
        channel_up <= 1'b1;
        repeat (2) @(negedge pclk);
        chk("on_req", 32'h1, {31'h0, comp_request});
    endtask
    task t_hotplug;
        int n;
        n = 0;
        @(posedge pclk);
        echo_en <= 1'b0;
        while (link_reset !== 1'b1 && n < 300) begin
            @(negedge pclk);
            n++;
        end
        chk("lrst_seen", 32'h1, {31'h0, link_reset});
        n = 0;
        while (link_reset === 1'b1 && n < 300) begin
            @(negedge pclk);
            n++;
        end
        chk("lrst_len", 32'h80, n);
        @(posedge pclk);
        echo_en <= 1'b1;
    endtask
    task give_verdict;
        if (miscompares == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        channel_up = 1'b0;
        echo_en = 1'b1;
        repeat (16) @(posedge pclk);
        // Reset stands until the clock has settled, as a PLL lock would allow.
        presetn <= 1'b1;
        t_regs();
        t_sched();
        t_down();
        t_off();
        t_hotplug();
        repeat (50) @(posedge pclk);
        give_verdict();
    end
    // The tests need well under a thousand cycles; four thousand leaves margin.
    initial begin
        #160000;
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
